/* tb/scco_top_tb.sv */
`timescale 1ns/1ps
`include "scco_defs.svh"
module scco_top_tb import scco_pkg::*;;
    logic        clk_sys, arst_n, reg_wr, reg_rd, usb_mode, halted;
    logic        rc_clk_tick, wdt_clr_instr, other_instr, rd_pend;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, me;
    logic [9:0]  wake_pins;
    scco_opt_t   opt;
    logic        usb_clock_gate, clk_6mhz_mode, deep_suspend_active, brownout_reset_en;
    logic        mouse_port_mode, wdt_tick, wdt_refresh, wake_event;
    logic [4:0]  table_ptr_upper_bits;
    logic [15:0] pa_drive, ep;
    logic [17:0] pull_high_en;
    logic [5:0]  pull_low_en;
    logic [7:0]  exp_q[$];
    int          num_errors, total_checks, cycles, seed, n_ref, n_wake, n_tick, b;

    scco_top i_scco_top (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .opt(opt), .usb_mode(usb_mode), .halted(halted), .rc_clk_tick(rc_clk_tick),
        .wdt_clr_instr(wdt_clr_instr), .other_instr(other_instr), .wake_pins(wake_pins),
        .usb_clock_gate(usb_clock_gate), .clk_6mhz_mode(clk_6mhz_mode),
        .deep_suspend_active(deep_suspend_active), .brownout_reset_en(brownout_reset_en),
        .mouse_port_mode(mouse_port_mode), .table_ptr_upper_bits(table_ptr_upper_bits),
        .wdt_tick(wdt_tick), .wdt_refresh(wdt_refresh), .wake_event(wake_event),
        .pa_drive(pa_drive), .pull_high_en(pull_high_en), .pull_low_en(pull_low_en));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // read data stands only in the cycle after the strobe, so look mid-cycle
    always @(posedge clk_sys) rd_pend <= reg_rd;
    always @(negedge clk_sys) begin
        if (rd_pend === 1'b1) begin
            me = exp_q.pop_front();
            chk(reg_rdata, me, "read data");
        end
    end

    // pulse tallies; only this process writes them, scenarios take differences
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (wdt_refresh === 1'b1) n_ref <= n_ref + 1;
        if (wake_event === 1'b1) n_wake <= n_wake + 1;
        if (wdt_tick === 1'b1) n_tick <= n_tick + 1;
        if (cycles == 6000) begin
            num_errors++;
            report_and_stop;
        end
    end

    // idle releases every strobe; transfers leave theirs up for a back-to-back call
    task automatic idle(input int n);
        reg_wr        <= 1'b0;
        reg_rd        <= 1'b0;
        wdt_clr_instr <= 1'b0;
        other_instr   <= 1'b0;
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic rst;
        arst_n <= 1'b0;
        idle(6);
        arst_n <= 1'b1;
        idle(2);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        exp_q.push_back(v);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        reg_wr   <= 1'b0;
        @(posedge clk_sys);
    endtask

    // a pulse of clear or other instruction, n cycles long
    task automatic instr(input logic clr, input int n);
        wdt_clr_instr <= clr;
        other_instr   <= ~clr;
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic done(input string s);
        idle(3);
        $display("test %s done", s);
    endtask

    initial begin
        seed = 82537;
        arst_n = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
        usb_mode = 1'b0; halted = 1'b0; rc_clk_tick = 1'b0; wdt_clr_instr = 1'b0;
        other_instr = 1'b0; wake_pins = 10'h3ff; rd_pend = 1'b0;
        opt = '0;
        rst();
        // defaults after power-on
        chk(usb_clock_gate, 1'b0, "usb gate");
        chk(clk_6mhz_mode, 1'b0, "clk sel");
        chk(mouse_port_mode, 1'b0, "mode flag");
        chk(brownout_reset_en, 1'b1, "brownout");
        chk(pa_drive, 16'h0000, "drive");
        chk(pull_high_en, 18'h3ffff, "pull high");
        chk(pull_low_en, 6'h00, "pull low");
        rd(`SCCO_OFS_CLKCTL, 8'h00);
        wr(`SCCO_OFS_TBLPTR, 8'h1f);
        rd(`SCCO_OFS_TBLPTR, 8'h00);
        done("reset");
        // unmapped offset 1d stores nothing; usb enable, clock select and mode flag land on their outputs
        wr(`SCCO_OFS_CLKCTL, 8'hc8);
        rd(`SCCO_OFS_CLKCTL, 8'hc8);
        wr(8'h1d, 8'hff);
        rd(8'h1d, 8'h00);
        rd(`SCCO_OFS_CLKCTL, 8'hc8);
        idle(2);
        chk({usb_clock_gate, clk_6mhz_mode, mouse_port_mode}, 3'h7, "fields");
        for (int i = 0; i < 12; i++) begin
            d = 8'($random(seed)) & 8'hc8;
            wr(`SCCO_OFS_CLKCTL, d);
            rd(`SCCO_OFS_CLKCTL, d & 8'hd8);
        end
        done("clkctl");
        // deep suspend only takes effect in halt and kills brownout reset
        wr(`SCCO_OFS_CLKCTL, 8'h10);
        idle(3);
        chk(deep_suspend_active, 1'b0, "suspend run");
        halted <= 1'b1;
        idle(3);
        chk({deep_suspend_active, brownout_reset_en}, 2'h2, "suspend halt");
        halted <= 1'b0;
        usb_mode <= 1'b1;
        idle(4);
        rd(`SCCO_OFS_CLKCTL, 8'h00);
        wr(`SCCO_OFS_CLKCTL, 8'hd8);
        rd(`SCCO_OFS_CLKCTL, 8'hc8);
        halted <= 1'b1;
        idle(3);
        chk({deep_suspend_active, brownout_reset_en}, 2'h1, "usb halt");
        halted <= 1'b0;
        usb_mode <= 1'b0;
        wr(`SCCO_OFS_CLKCTL, 8'h00);
        done("suspend");
        // table pointer, one-clear watchdog, sys/4 tick, pin options
        d = $random(seed);
        opt.tblptr_enable <= 1'b1; opt.wdt_src_sys4 <= 1'b1; opt.wdt_run_normal <= 1'b1;
        opt.brownout_disable <= 1'b1; opt.pa_nmos <= d; opt.pa_pmos <= ~d & 8'h5a;
        opt.pa_pull_high_off <= 8'($random(seed)); opt.pb_pull_high_off <= 8'($random(seed));
        opt.pc_pull_high_off <= 2'h1; opt.pull_low_on <= 6'($random(seed));
        rst();
        for (int i = 0; i < 8; i++) begin
            ep[2*i +: 2] = opt.pa_nmos[i] ? 2'h1 : (opt.pa_pmos[i] ? 2'h2 : 2'h0);
        end
        chk(pa_drive, ep, "drive");
        chk(pull_high_en, {2'h2, ~opt.pb_pull_high_off, ~opt.pa_pull_high_off},
            "pull high");
        chk(pull_low_en, opt.pull_low_on, "pull low");
        chk(brownout_reset_en, 1'b0, "brownout off");
        d = $random(seed);
        wr(`SCCO_OFS_TBLPTR, d);
        rd(`SCCO_OFS_TBLPTR, {3'h0, d[4:0]});
        idle(2);
        chk(table_ptr_upper_bits, d[4:0], "ptr out");
        b = n_tick;
        idle(40);
        chk(n_tick - b, 10, "sys4 ticks");
        b = n_ref;
        instr(1'b1, 1);
        idle(6);
        chk(n_ref - b, 1, "one clear");
        done("options");
        // two-clear watchdog: a broken pair refreshes nothing; rc source and gate
        opt.wdt_clr_two <= 1'b1; opt.wdt_src_sys4 <= 1'b0; opt.wdt_run_normal <= 1'b0;
        rst();
        b = n_ref;
        instr(1'b1, 1);
        instr(1'b0, 1);
        instr(1'b1, 1);
        idle(6);
        chk(n_ref - b, 0, "broken pair");
        instr(1'b1, 1);
        idle(6);
        chk(n_ref - b, 1, "pair");
        b = n_tick;
        repeat (5) begin
            rc_clk_tick <= ~rc_clk_tick;
            idle(4);
        end
        chk(n_tick - b, 0, "gated in normal");
        opt.wdt_run_normal <= 1'b1;
        rst();
        b = n_tick;
        repeat (10) begin
            rc_clk_tick <= ~rc_clk_tick;
            idle(4);
        end
        chk(n_tick - b > 0, 1'b1, "rc ticks");
        done("watchdog");
        // wake: pa1 masked, pa0 falling, pa2 rising only
        opt.wake_enable <= 10'h005; opt.wake_rising <= 2'h1;
        rst();
        b = n_wake;
        wake_pins <= 10'h3fd;
        idle(12);
        chk(n_wake - b, 0, "masked pin");
        wake_pins <= 10'h3fe;
        idle(12);
        chk(n_wake - b, 1, "falling pin");
        wake_pins <= 10'h3fb;
        idle(12);
        wake_pins <= 10'h3ff;
        idle(12);
        chk(n_wake - b, 2, "rising pin");
        done("wake");
        report_and_stop;
    end
endmodule

/* verilog/scco_defs.svh */
`ifndef SCCO_DEFS_SVH
`define SCCO_DEFS_SVH
// register offsets
`define SCCO_OFS_CLKCTL      8'h1c
`define SCCO_OFS_TBLPTR      8'h1f
// clock control field positions
`define SCCO_BIT_USB_CLOCK_ENABLE     3
`define SCCO_BIT_DEEPSUSP    4
`define SCCO_BIT_CLKSEL      6
`define SCCO_BIT_PS2FLAG     7
`define SCCO_RSV_MASK        8'h27
// reset values
`define SCCO_CLKCTL_RST      4'h0 // packed {mode flag, clock select, deep suspend, usb enable}
`define SCCO_TBLPTR_RST      5'h00
// divider for watchdog clock from system clock
`define SCCO_WDT_DIV         2'h3
`endif

/* verilog/scco_pin_opts.sv */
`timescale 1ns/1ps
// turns mask options into per-pin pull, drive and wake controls
module scco_pin_opts import scco_pkg::*; (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire scco_opt_t   opt,
    input  wire logic [9:0]  wake_pins,
    output logic [15:0]      pa_drive,
    output logic [17:0]      pull_high_en,
    output logic [5:0]       pull_low_en,
    output logic             wake_event
);
    logic [9:0] s1_r;
    logic [9:0] s2_r;
    logic [9:0] s3_r;
    logic [9:0] hit;
    logic       wake_nxt;
    // pins are asynchronous: two flops before use, a third for edges
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s1_r <= 10'h3ff;
            s2_r <= 10'h3ff;
            s3_r <= 10'h3ff;
            wake_event <= 1'b0;
        end else begin
            s1_r <= wake_pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            wake_event <= wake_nxt;
        end
    end
    // falling edge wakes; pins 2 and 3 may take rising edge instead
    genvar i;
    for (i = 0; i < 10; i++) begin : g_wake
        if (i == 2 || i == 3) begin : g_dual
            assign hit[i] = opt.wake_enable[i] & (opt.wake_rising[i-2] ?
                            (s2_r[i] & ~s3_r[i]) : (~s2_r[i] & s3_r[i])); // R13
        end else begin : g_fall
            assign hit[i] = opt.wake_enable[i] & ~s2_r[i] & s3_r[i]; // R13
        end
    end
    assign wake_nxt = |hit;
    // drive type per bit, cmos unless an open-drain option is set
    for (i = 0; i < 8; i++) begin : g_drive
        assign pa_drive[2*i+1:2*i] = opt.pa_nmos[i] ? SCCO_NMOS_OD :
                                     opt.pa_pmos[i] ? SCCO_PMOS_OD : SCCO_CMOS; // R15
    end
    // option bits are "off" sense so an unprogrammed option keeps pull-high
    // port c has one control bit per nibble, so one enable per nibble
    assign pull_high_en = ~{opt.pc_pull_high_off, opt.pb_pull_high_off,
                            opt.pa_pull_high_off}; // R16
    assign pull_low_en  = opt.pull_low_on; // R16
endmodule

/* verilog/scco_pkg.sv */
package scco_pkg;
    // software-visible clock control view
    typedef struct packed {
        logic mouse_port_mode_flag;
        logic sys_clock_select;
        logic deep_suspend;
        logic usb_clock_enable;
    } scco_clkctl_t;
    // mask-time configuration options
    typedef struct packed {
        logic       wdt_src_sys4;
        logic       wdt_run_normal;
        logic       wdt_clr_two;
        logic       brownout_disable;
        logic       tblptr_enable;
        logic [9:0] wake_enable;
        logic [1:0] wake_rising;
        logic [7:0] pa_nmos;
        logic [7:0] pa_pmos;
        logic [7:0] pa_pull_high_off;
        logic [7:0] pb_pull_high_off;
        logic [1:0] pc_pull_high_off;
        logic [5:0] pull_low_on;
    } scco_opt_t;
    // drive style per port a pin
    typedef enum logic [1:0] {SCCO_CMOS, SCCO_NMOS_OD, SCCO_PMOS_OD} scco_drive_t;
endpackage

/* verilog/scco_top.sv */
`timescale 1ns/1ps
`include "scco_defs.svh"
// Contract
// [R01] bit 3 gates the usb side clock, reset to 0
// [R02] firmware keeps deep suspend at 0 in normal operation
// [R03] deep suspend in halt cuts power and disables brownout reset
// [R04] deep suspend cannot be set while in usb mode
// [R05] bit 6 selects 12 MHz (0) or 6 MHz (1), reset 0
// [R06] bit 7 mouse port mode flag, rw, cleared by power-on reset
// [R07] firmware writes 0 to reserved bits 0-2 and 5
// [R08] table pointer high holds address bits 12-8, read and write
// [R09] option enables table pointer high; disabled by default
// [R10] option picks watchdog clock: rc or system divided by four
// [R11] option enables watchdog clock in normal mode; default off
// [R12] watchdog refresh after one or two consecutive clear instructions
// [R13] per-pin wake on port a and two port b pins, off default
// [R14] option disables brownout reset; enabled by default
// [R15] port a drive per bit: cmos, nmos or pmos open drain
// [R16] pull-high per bit/nibble enabled default; pull-low six pins off
module scco_top import scco_pkg::*; (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    input  wire scco_opt_t   opt,
    input  wire logic        usb_mode,
    input  wire logic        halted,
    input  wire logic        rc_clk_tick,
    input  wire logic        wdt_clr_instr,
    input  wire logic        other_instr,
    input  wire logic [9:0]  wake_pins,
    output logic             usb_clock_gate,
    output logic             clk_6mhz_mode,
    output logic             deep_suspend_active,
    output logic             brownout_reset_en,
    output logic             mouse_port_mode,
    output logic [4:0]       table_ptr_upper_bits,
    output logic             wdt_tick,
    output logic             wdt_refresh,
    output logic             wake_event,
    output logic [15:0]      pa_drive,
    output logic [17:0]      pull_high_en,
    output logic [5:0]       pull_low_en
);
    scco_clkctl_t clkctl_r;
    scco_clkctl_t clkctl_nxt;
    logic [4:0]   tblptr_r;
    logic [4:0]   tblptr_nxt;
    logic [7:0]   rdata_nxt;
    logic [1:0]   div_r;
    logic [1:0]   div_nxt;
    logic         rc_s1_r;
    logic         rc_s2_r;
    logic         rc_s3_r;
    logic         usb_s1_r;
    logic         usb_s2_r;
    logic         tick_nxt;
    logic         bor_nxt;
    logic         refresh_w;
    logic         wake_w;
    logic [15:0]  drive_w;
    logic [17:0]  ph_w;
    logic [5:0]   pl_w;

    // register writes; reserved bits are not stored, so they read back 0
    always_comb begin
        clkctl_nxt = clkctl_r;
        tblptr_nxt = tblptr_r;
        if (reg_wr && reg_addr == `SCCO_OFS_CLKCTL) begin
            clkctl_nxt.usb_clock_enable     = reg_wdata[`SCCO_BIT_USB_CLOCK_ENABLE]; // R01
            clkctl_nxt.deep_suspend         = reg_wdata[`SCCO_BIT_DEEPSUSP]; // R02
            clkctl_nxt.sys_clock_select     = reg_wdata[`SCCO_BIT_CLKSEL]; // R05
            clkctl_nxt.mouse_port_mode_flag = reg_wdata[`SCCO_BIT_PS2FLAG]; // R06
        end
        if (reg_wr && reg_addr == `SCCO_OFS_TBLPTR && opt.tblptr_enable) begin
            tblptr_nxt = reg_wdata[4:0]; // R08 R09
        end
        // usb mode forbids deep suspend; also clears a bit set before usb began
        if (usb_s2_r) begin
            clkctl_nxt.deep_suspend = 1'b0; // R04
        end
    end

    // read data stands only in the cycle after the strobe
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `SCCO_OFS_CLKCTL: begin
                    rdata_nxt[`SCCO_BIT_USB_CLOCK_ENABLE]  = clkctl_r.usb_clock_enable;
                    rdata_nxt[`SCCO_BIT_DEEPSUSP] = clkctl_r.deep_suspend;
                    rdata_nxt[`SCCO_BIT_CLKSEL]   = clkctl_r.sys_clock_select;
                    rdata_nxt[`SCCO_BIT_PS2FLAG]  = clkctl_r.mouse_port_mode_flag;
                end
                `SCCO_OFS_TBLPTR: begin
                    rdata_nxt[4:0] = opt.tblptr_enable ? tblptr_r : 5'h00; // R09
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    // watchdog clock: rc tick (synchronised) or system/4, gated in normal mode unless wdt_run_normal is set
    always_comb begin
        div_nxt  = div_r + 2'h1;
        tick_nxt = 1'b0;
        if (halted || opt.wdt_run_normal) begin // R11
            if (opt.wdt_src_sys4) begin
                tick_nxt = (div_r == `SCCO_WDT_DIV); // R10
            end else begin
                tick_nxt = rc_s2_r & ~rc_s3_r; // R10
            end
        end
    end

    // brownout reset: option may disable; deep suspend in halt also removes it
    always_comb begin
        bor_nxt = ~opt.brownout_disable; // R14
        if (halted && clkctl_r.deep_suspend) begin
            bor_nxt = 1'b0; // R03
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            clkctl_r  <= scco_clkctl_t'(`SCCO_CLKCTL_RST); // R01 R05 R06
            tblptr_r  <= `SCCO_TBLPTR_RST;
            reg_rdata <= 8'h00;
            div_r     <= 2'h0;
            rc_s1_r   <= 1'b0;
            rc_s2_r   <= 1'b0;
            rc_s3_r   <= 1'b0;
            usb_s1_r  <= 1'b0;
            usb_s2_r  <= 1'b0;
            wdt_tick  <= 1'b0;
            brownout_reset_en   <= 1'b1;
            usb_clock_gate      <= 1'b0;
            clk_6mhz_mode       <= 1'b0;
            deep_suspend_active <= 1'b0;
            mouse_port_mode     <= 1'b0;
            table_ptr_upper_bits <= 5'h00;
        end else begin
            clkctl_r  <= clkctl_nxt;
            tblptr_r  <= tblptr_nxt;
            reg_rdata <= rdata_nxt;
            div_r     <= div_nxt;
            rc_s1_r   <= rc_clk_tick;
            rc_s2_r   <= rc_s1_r;
            rc_s3_r   <= rc_s2_r;
            usb_s1_r  <= usb_mode;
            usb_s2_r  <= usb_s1_r;
            wdt_tick  <= tick_nxt;
            brownout_reset_en   <= bor_nxt;
            usb_clock_gate      <= clkctl_r.usb_clock_enable; // R01
            clk_6mhz_mode       <= clkctl_r.sys_clock_select; // R05
            deep_suspend_active <= halted & clkctl_r.deep_suspend; // R03
            mouse_port_mode     <= clkctl_r.mouse_port_mode_flag; // R06
            table_ptr_upper_bits <= opt.tblptr_enable ? tblptr_r : 5'h00; // R08
        end
    end

    // second-stage flops keep every top output straight from a register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wdt_refresh  <= 1'b0;
            wake_event   <= 1'b0;
            pa_drive     <= 16'h0000;
            pull_high_en <= 18'h3ffff;
            pull_low_en  <= 6'h00;
        end else begin
            wdt_refresh  <= refresh_w;
            wake_event   <= wake_w;
            pa_drive     <= drive_w;
            pull_high_en <= ph_w;
            pull_low_en  <= pl_w;
        end
    end

    scco_wdt_clear u_wdt_clear (
        .clk_sys     (clk_sys),
        .arst_n      (arst_n),
        .two_needed  (opt.wdt_clr_two),
        .clr_instr   (wdt_clr_instr),
        .other_instr (other_instr),
        .refresh     (refresh_w)
    );

    scco_pin_opts u_pin_opts (
        .clk_sys      (clk_sys),
        .arst_n       (arst_n),
        .opt          (opt),
        .wake_pins    (wake_pins),
        .pa_drive     (drive_w),
        .pull_high_en (ph_w),
        .pull_low_en  (pl_w),
        .wake_event   (wake_w)
    );

    AST_USB_NO_SUSP: assert property (@(posedge clk_sys) disable iff (!arst_n) // R04
        usb_s2_r |=> !clkctl_r.deep_suspend)
        else $error("deep suspend set in usb mode");
    AST_USB_SIDE_CLOCK_GATE: assert property (@(posedge clk_sys) disable iff (!arst_n) // R01
        (reg_wr && reg_addr == `SCCO_OFS_CLKCTL) |=> ##1
        usb_clock_gate == $past(reg_wdata[`SCCO_BIT_USB_CLOCK_ENABLE], 2))
        else $error("usb clock gate does not follow bit 3");
    AST_CLKSEL: assert property (@(posedge clk_sys) disable iff (!arst_n) // R05
        (reg_wr && reg_addr == `SCCO_OFS_CLKCTL) |=> ##1
        clk_6mhz_mode == $past(reg_wdata[`SCCO_BIT_CLKSEL], 2))
        else $error("clock select mismatch");
    AST_PS2_RD: assert property (@(posedge clk_sys) disable iff (!arst_n) // R06
        (reg_rd && reg_addr == `SCCO_OFS_CLKCTL) |=>
        reg_rdata[`SCCO_BIT_PS2FLAG] == $past(clkctl_r.mouse_port_mode_flag))
        else $error("mode flag readback wrong");
    AST_RSV_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n) // R07
        $past(reg_rd && reg_addr == `SCCO_OFS_CLKCTL) |-> (reg_rdata & `SCCO_RSV_MASK) == 8'h00)
        else $error("reserved bits read nonzero");
    AST_TBL_RW: assert property (@(posedge clk_sys) disable iff (!arst_n) // R08
        (reg_wr && reg_addr == `SCCO_OFS_TBLPTR && opt.tblptr_enable) ##1
        (reg_rd && reg_addr == `SCCO_OFS_TBLPTR && opt.tblptr_enable) |=>
        reg_rdata[4:0] == $past(reg_wdata[4:0], 2))
        else $error("table pointer readback wrong");
    AST_TBL_OFF: assert property (@(posedge clk_sys) disable iff (!arst_n) // R09
        !opt.tblptr_enable ##1 !opt.tblptr_enable |-> table_ptr_upper_bits == 5'h00)
        else $error("table pointer active while disabled");
    AST_WDT_GATE: assert property (@(posedge clk_sys) disable iff (!arst_n) // R11
        (!halted && !opt.wdt_run_normal) |=> !wdt_tick)
        else $error("watchdog ticked in normal mode while disabled");
    AST_WDT_DIV4: assert property (@(posedge clk_sys) disable iff (!arst_n) // R10
        (opt.wdt_src_sys4 && opt.wdt_run_normal && wdt_tick) [*1] ##1
        (opt.wdt_src_sys4 && opt.wdt_run_normal) [*3] |-> !wdt_tick)
        else $error("system/4 tick too frequent");
    AST_BOR: assert property (@(posedge clk_sys) disable iff (!arst_n) // R03
        (halted && clkctl_r.deep_suspend) |=> !brownout_reset_en)
        else $error("brownout reset active in deep suspend halt");
    AST_BOR_OPT: assert property (@(posedge clk_sys) disable iff (!arst_n) // R14
        (!halted && !opt.brownout_disable) |=> brownout_reset_en)
        else $error("brownout reset not enabled");
    COV_USB_ON: cover property (@(posedge clk_sys) disable iff (!arst_n) usb_clock_gate);
    COV_DEEP: cover property (@(posedge clk_sys) disable iff (!arst_n) deep_suspend_active);
    COV_WAKE: cover property (@(posedge clk_sys) disable iff (!arst_n) wake_event);
endmodule

/* verilog/scco_wdt_clear.sv */
`timescale 1ns/1ps
// qualifies watchdog clear instructions: one or two in a row
module scco_wdt_clear import scco_pkg::*; (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic two_needed,
    input  wire logic clr_instr,
    input  wire logic other_instr,
    output logic      refresh
);
    logic armed_r;
    logic armed_nxt;
    logic refresh_nxt;
    // a second clear must follow the first with no other instruction between
    always_comb begin
        armed_nxt   = armed_r;
        refresh_nxt = 1'b0;
        if (clr_instr) begin
            if (!two_needed || armed_r) begin
                refresh_nxt = 1'b1; // R12
                armed_nxt   = 1'b0;
            end else begin
                armed_nxt = 1'b1;
            end
        end else if (other_instr) begin
            armed_nxt = 1'b0;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            armed_r <= 1'b0;
            refresh <= 1'b0;
        end else begin
            armed_r <= armed_nxt;
            refresh <= refresh_nxt;
        end
    end
    AST_WDT_ONE: assert property (@(posedge clk_sys) disable iff (!arst_n) // R12
        (clr_instr && !two_needed) |=> refresh)
        else $error("single clear did not refresh");
    AST_WDT_TWO: assert property (@(posedge clk_sys) disable iff (!arst_n) // R12
        (two_needed && clr_instr && !armed_r) |=> !refresh)
        else $error("lone clear refreshed in two-clear mode");
    COV_WDT_PAIR: cover property (@(posedge clk_sys) disable iff (!arst_n)
        two_needed && clr_instr ##1 clr_instr);
endmodule
